//--- verilog/rqgt_device.sv
// processor end: request/grant arbitration, t-state sequencing and exclusive-bus output
`timescale 1ns/1ps
`default_nettype none
module rqgt_device (
    // clock and reset
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    // pins
    rqgt_if.dev PINS,
    // mode strap
    input wire logic MIN_MAX_STRAP_I,
    // bus cycle requests from the execution side
    input wire logic CYCLE_REQ_I,
    input wire logic [2:0] CYCLE_KIND_I,
    input wire logic ODD_WORD_I,
    // instruction events
    input wire logic LOCK_PREFIX_I,
    input wire logic INSTR_DONE_I,
    // observed state
    output logic [2:0] T_STATE_O,
    output logic CYCLE_START_O,
    output logic BUS_HELD_O,
    output logic HELD_LINE_O
);
    rqgt_pkg::tstate_t t_reg;
    rqgt_pkg::tstate_t t_next;
    rqgt_pkg::arb_t arb_reg;
    rqgt_pkg::arb_t arb_next;
    logic sel_reg;
    logic sel_next;
    logic in_time_reg;
    logic in_time_next;
    logic cyc_reg;
    logic cyc_next;
    logic odd_reg;
    logic odd_next;
    logic [2:0] kind_reg;
    logic [2:0] kind_next;
    logic [2:0] status_reg;
    logic [2:0] status_next;
    logic ack_first_reg;
    logic ack_first_next;
    logic lock_pfx_reg;
    logic lock_pfx_next;
    logic max_mode;
    logic locked;
    logic edge_ok;
    logic grant_go;
    logic release_seen;
    logic start;
    logic floating;

    ////////////////////////////////////////////////////////////////////////////
    // release qualification
    assign max_mode = (MIN_MAX_STRAP_I == rqgt_pkg::STRAP_MAX);
    assign locked = lock_pfx_reg | ack_first_reg;
    // a T4 only qualifies once the cycle's byte or acknowledge pair is complete
    assign edge_ok = (t_reg == rqgt_pkg::TS_TI) ||
        ((t_reg == rqgt_pkg::TS_T4) && !odd_reg && !ack_first_reg);
    assign grant_go = (arb_reg == rqgt_pkg::ARB_PEND) && edge_ok &&
        in_time_reg && !locked;
    assign release_seen = (arb_reg == rqgt_pkg::ARB_HELD) && !PINS.rg_n[sel_reg];
    assign floating = grant_go || (arb_reg == rqgt_pkg::ARB_HELD);

    ////////////////////////////////////////////////////////////////////////////
    // arbiter next state
    always_comb begin
        arb_next = arb_reg;
        sel_next = sel_reg;
        in_time_next = in_time_reg;
        unique case (arb_reg)
            rqgt_pkg::ARB_IDLE: begin
                if (max_mode && (!PINS.rg_n[rqgt_pkg::LINE_HI] || !PINS.rg_n[rqgt_pkg::LINE_LO])) begin
                    // high line checked first so it wins a simultaneous request
                    sel_next = PINS.rg_n[rqgt_pkg::LINE_HI];
                    arb_next = rqgt_pkg::ARB_PEND;
                    in_time_next = (t_reg == rqgt_pkg::TS_TI) || (t_reg == rqgt_pkg::TS_T1) ||
                        (t_reg == rqgt_pkg::TS_T2);
                end
            end
            rqgt_pkg::ARB_PEND: begin
                // the other line is not looked at until this exchange ends
                if (grant_go) begin
                    arb_next = rqgt_pkg::ARB_HELD;
                end else if ((t_reg == rqgt_pkg::TS_T1) || (t_reg == rqgt_pkg::TS_TI)) begin
                    // a late request must ripen on an idle clock too, or a quiet bus never grants
                    in_time_next = 1'b1;
                end
            end
            rqgt_pkg::ARB_HELD: begin
                if (release_seen) begin
                    arb_next = rqgt_pkg::ARB_GAP;
                end
            end
            rqgt_pkg::ARB_GAP: begin
                arb_next = rqgt_pkg::ARB_IDLE;
                in_time_next = 1'b0;
            end
            default: arb_next = rqgt_pkg::ARB_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // t-state sequencer next state, no wait states
    always_comb begin
        t_next = t_reg;
        cyc_next = cyc_reg;
        start = 1'b0;
        unique case (t_reg)
            rqgt_pkg::TS_TI: begin
                if (grant_go) begin
                    t_next = rqgt_pkg::TS_TH;
                end else if (CYCLE_REQ_I) begin
                    t_next = rqgt_pkg::TS_T1;
                    start = 1'b1;
                end
            end
            rqgt_pkg::TS_T1: begin
                // T1 entered on reclaim with nothing pending falls back to idle
                t_next = cyc_reg ? rqgt_pkg::TS_T2 : rqgt_pkg::TS_TI;
            end
            rqgt_pkg::TS_T2: t_next = rqgt_pkg::TS_T3;
            rqgt_pkg::TS_T3: t_next = rqgt_pkg::TS_T4;
            rqgt_pkg::TS_T4: begin
                if (grant_go) begin
                    t_next = rqgt_pkg::TS_TH;
                end else if (CYCLE_REQ_I) begin
                    t_next = rqgt_pkg::TS_T1;
                    start = 1'b1;
                end else begin
                    t_next = rqgt_pkg::TS_TI;
                end
            end
            rqgt_pkg::TS_TH: begin
                // held: no cycle may start until the release pulse
                if (release_seen) begin
                    t_next = CYCLE_REQ_I ? rqgt_pkg::TS_T4 : rqgt_pkg::TS_T1;
                end
            end
            default: t_next = rqgt_pkg::TS_TI;
        endcase
        if (start) begin
            cyc_next = 1'b1;
        end else if (t_reg == rqgt_pkg::TS_T4 || t_reg == rqgt_pkg::TS_TH) begin
            cyc_next = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // cycle attributes, status code and exclusive-bus sources
    always_comb begin
        kind_next = kind_reg;
        odd_next = odd_reg;
        status_next = status_reg;
        ack_first_next = ack_first_reg;
        lock_pfx_next = lock_pfx_reg;
        if (start) begin
            kind_next = CYCLE_KIND_I;
            odd_next = ODD_WORD_I;
            status_next = CYCLE_KIND_I;
        end else if (t_reg == rqgt_pkg::TS_T2) begin
            status_next = rqgt_pkg::STATUS_PASSIVE;
        end
        // toggles at T2 of each acknowledge in max mode: set by the first, cleared by the second
        if (max_mode && t_reg == rqgt_pkg::TS_T2 && kind_reg == rqgt_pkg::STATUS_IRQ_ACK) begin
            ack_first_next = ~ack_first_reg;
        end
        // a new lock prefix wins over the completion of the previous instruction
        if (LOCK_PREFIX_I) begin
            lock_pfx_next = 1'b1;
        end else if (INSTR_DONE_I) begin
            lock_pfx_next = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            t_reg <= rqgt_pkg::TS_TI;
            arb_reg <= rqgt_pkg::ARB_IDLE;
            sel_reg <= 1'b0;
            in_time_reg <= 1'b0;
            cyc_reg <= 1'b0;
            odd_reg <= 1'b0;
            kind_reg <= rqgt_pkg::STATUS_PASSIVE;
            status_reg <= rqgt_pkg::STATUS_PASSIVE;
            ack_first_reg <= 1'b0;
            lock_pfx_reg <= 1'b0;
            CYCLE_START_O <= 1'b0;
        end else begin
            t_reg <= t_next;
            arb_reg <= arb_next;
            sel_reg <= sel_next;
            in_time_reg <= in_time_next;
            cyc_reg <= cyc_next;
            odd_reg <= odd_next;
            kind_reg <= kind_next;
            status_reg <= status_next;
            ack_first_reg <= ack_first_next;
            lock_pfx_reg <= lock_pfx_next;
            CYCLE_START_O <= start;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drive: grant pulse only on the requesting line, only for one clock
    generate
        for (genvar i = 0; i < rqgt_pkg::NUM_LINES; i++) begin : g_line
            assign PINS.dev_rg_o[i] = 1'b0;
            assign PINS.dev_rg_oe[i] = grant_go && (sel_reg == 1'(i));
        end
    endgenerate

    // exclusive-bus and status float while granted, keeper holds them high
    assign PINS.bus_exclusive_n_o = ~locked;
    assign PINS.bus_exclusive_n_oe = max_mode && !floating;
    assign PINS.status_o = status_reg;
    assign PINS.status_oe = !floating;

    // observed state
    assign T_STATE_O = t_reg;
    assign BUS_HELD_O = (arb_reg == rqgt_pkg::ARB_HELD);
    assign HELD_LINE_O = sel_reg;
endmodule // rqgt_device
`default_nettype wire

//--- pkg/rqgt_pkg.sv
// shared types and constants for the local bus request/grant exchange
package rqgt_pkg;
    // processor bus cycle t-states, TS_TH is the granted (floating) state
    typedef enum logic [2:0] {
        TS_TI = 3'h0,
        TS_T1 = 3'h1,
        TS_T2 = 3'h2,
        TS_T3 = 3'h3,
        TS_T4 = 3'h4,
        TS_TH = 3'h5
    } tstate_t;
    // device-side arbiter states
    typedef enum logic [1:0] {
        ARB_IDLE = 2'h0,
        ARB_PEND = 2'h1,
        ARB_HELD = 2'h2,
        ARB_GAP = 2'h3
    } arb_t;
    // requesting master states
    typedef enum logic [2:0] {
        M_IDLE = 3'h0,
        M_REQ = 3'h1,
        M_WAIT = 3'h2,
        M_OWN = 3'h3,
        M_REL = 3'h4,
        M_GAP = 3'h5
    } mst_t;
    localparam int NUM_LINES = 2;
    localparam int LINE_HI = 0;
    localparam int LINE_LO = 1;
    localparam logic STRAP_MAX = 1'b0;
    localparam logic [2:0] STATUS_PASSIVE = 3'h7;
    localparam logic [2:0] STATUS_IRQ_ACK = 3'h0;
endpackage

//--- pkg/rqgt_if.sv
// request/grant lines, exclusive-bus and status pins between the processor and a local master
`timescale 1ns/1ps
`default_nettype none
interface rqgt_if;
    // per-line drivers of each end, active-low open-drain style
    logic [1:0] dev_rg_o;
    logic [1:0] dev_rg_oe;
    logic [1:0] mst_rg_o;
    logic [1:0] mst_rg_oe;
    // processor-driven pins
    logic bus_exclusive_n_o;
    logic bus_exclusive_n_oe;
    logic [2:0] status_o;
    logic status_oe;
    // resolved pin levels
    logic [1:0] rg_n;
    logic bus_exclusive_n;
    logic [2:0] status;

    // pull-up bus hold: an undriven line reads high and never requests
    assign rg_n = ~((dev_rg_oe & ~dev_rg_o) | (mst_rg_oe & ~mst_rg_o));
    // keeper holds floated pins at logic one
    assign bus_exclusive_n = bus_exclusive_n_oe ? bus_exclusive_n_o : 1'b1;
    assign status = status_oe ? status_o : rqgt_pkg::STATUS_PASSIVE;

    modport dev (
        output dev_rg_o, dev_rg_oe, bus_exclusive_n_o, bus_exclusive_n_oe, status_o, status_oe,
        input rg_n
    );
    modport mst (
        output mst_rg_o, mst_rg_oe,
        input rg_n, bus_exclusive_n, status
    );
endinterface
`default_nettype wire

//--- verilog/rqgt_master.sv
// requesting local bus master end of either request/grant line, picked by LINE_SEL_I at each request
`timescale 1ns/1ps
`default_nettype none
module rqgt_master (
    // clock and reset
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    // pins
    rqgt_if.mst PINS,
    // user side
    input wire logic LINE_SEL_I,
    input wire logic BUS_WANT_I,
    output logic BUS_OWNED_O,
    output logic BUSY_O
);
    rqgt_pkg::mst_t st_reg;
    rqgt_pkg::mst_t st_next;
    logic sel_reg;
    logic sel_next;
    logic seen_low;

    assign seen_low = ~PINS.rg_n[sel_reg];

    ////////////////////////////////////////////////////////////////////////////
    // next state: request pulse, wait grant, own, release pulse, idle gap
    always_comb begin
        st_next = st_reg;
        sel_next = sel_reg;
        unique case (st_reg)
            rqgt_pkg::M_IDLE: begin
                if (BUS_WANT_I && PINS.rg_n[LINE_SEL_I]) begin
                    sel_next = LINE_SEL_I;
                    st_next = rqgt_pkg::M_REQ;
                end
            end
            rqgt_pkg::M_REQ: st_next = rqgt_pkg::M_WAIT;
            rqgt_pkg::M_WAIT: begin
                if (seen_low) begin
                    st_next = rqgt_pkg::M_OWN;
                end
            end
            rqgt_pkg::M_OWN: begin
                if (!BUS_WANT_I) begin
                    st_next = rqgt_pkg::M_REL;
                end
            end
            rqgt_pkg::M_REL: st_next = rqgt_pkg::M_GAP;
            rqgt_pkg::M_GAP: st_next = rqgt_pkg::M_IDLE;
            default: st_next = rqgt_pkg::M_IDLE;
        endcase
    end

    // state registers
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            st_reg <= rqgt_pkg::M_IDLE;
            sel_reg <= 1'b0;
            BUS_OWNED_O <= 1'b0;
            BUSY_O <= 1'b0;
        end else begin
            st_reg <= st_next;
            sel_reg <= sel_next;
            BUS_OWNED_O <= (st_next == rqgt_pkg::M_OWN);
            BUSY_O <= (st_next != rqgt_pkg::M_IDLE);
        end
    end

    // drive the selected line low for exactly one clock per pulse
    generate
        for (genvar i = 0; i < rqgt_pkg::NUM_LINES; i++) begin : g_line
            assign PINS.mst_rg_o[i] = 1'b0;
            assign PINS.mst_rg_oe[i] = (sel_reg == 1'(i)) &&
                ((st_reg == rqgt_pkg::M_REQ) || (st_reg == rqgt_pkg::M_REL));
        end
    endgenerate
endmodule // rqgt_master
`default_nettype wire

//--- dv/rqgt_props.sv
// concurrent checks on the request/grant pins
`timescale 1ns/1ps
`default_nettype none
module rqgt_props (
    // clock and reset
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    // line drivers and levels
    input wire logic [1:0] dev_rg_oe_i,
    input wire logic [1:0] mst_rg_oe_i,
    input wire logic [1:0] rg_n_i,
    // floating pins
    input wire logic bus_exclusive_n_oe_i,
    input wire logic status_oe_i
);
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);
    logic held_ln;

    // line of the last grant, so a pulse on the other line is not taken for the release
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            held_ln <= 1'b0;
        end else if (|dev_rg_oe_i) begin
            held_ln <= dev_rg_oe_i[1];
        end
    end
    ////////////////////////////////////////
    // grant pulse shape and line choice
    property p_grant_pulse; (|dev_rg_oe_i) |=> (dev_rg_oe_i == 2'h0); endproperty
    a_grant_pulse: assert property (p_grant_pulse) else $error("grant pulse too long");
    property p_one_line; $onehot0(dev_rg_oe_i); endproperty
    a_one_line: assert property (p_one_line) else $error("grant on both lines");
    property p_excl_float; (|dev_rg_oe_i) |=> !bus_exclusive_n_oe_i; endproperty
    a_excl_float: assert property (p_excl_float) else $error("exclusive-bus driven while held");
    property p_no_clash; (dev_rg_oe_i & mst_rg_oe_i) == 2'h0; endproperty
    a_no_clash: assert property (p_no_clash) else $error("both ends pulse one line");
    property p_req_pulse; (|mst_rg_oe_i) |=> (mst_rg_oe_i == 2'h0); endproperty
    a_req_pulse: assert property (p_req_pulse) else $error("request pulse too long");
    ////////////////////////////////////////
    // float during hold, reclaim, then a gap before the next grant
    property p_float; (|dev_rg_oe_i) |-> (!bus_exclusive_n_oe_i && !status_oe_i); endproperty
    a_float: assert property (p_float) else $error("pins driven at grant");
    property p_float_span; (|dev_rg_oe_i) |-> (!status_oe_i) [*3]; endproperty
    a_float_span: assert property (p_float_span) else $error("hold ended early");
    property p_reclaim; (!status_oe_i && dev_rg_oe_i == 2'h0 && !rg_n_i[held_ln]) |=> status_oe_i; endproperty
    a_reclaim: assert property (p_reclaim) else $error("bus not reclaimed");
    property p_gap; $rose(status_oe_i) |-> (dev_rg_oe_i == 2'h0) [*2]; endproperty
    a_gap: assert property (p_gap) else $error("no idle clock after exchange");
endmodule // rqgt_props
`default_nettype wire

//--- dv/local_bus_request_grant_tb.sv
// self-checking bench: device and master joined by the pin interface
`timescale 1ns/1ps
`default_nettype none
module local_bus_request_grant_tb;
    logic clk;
    logic rst;
    logic strap;
    logic cyc_req;
    logic [2:0] cyc_kind;
    logic odd_word;
    logic lock_prefix;
    logic instr_done;
    logic line_sel;
    logic bus_want;
    logic [2:0] t_state;
    logic cyc_start;
    logic bus_held;
    logic held_line;
    logic bus_owned;
    logic busy;
    int error_cnt;
    int cmp_count;
    rqgt_if pins_if ();
    rqgt_device rqgt_device_i (.REF_CLK_I(clk), .RST_I(rst), .PINS(pins_if.dev), .MIN_MAX_STRAP_I(strap),
        .CYCLE_REQ_I(cyc_req), .CYCLE_KIND_I(cyc_kind), .ODD_WORD_I(odd_word), .LOCK_PREFIX_I(lock_prefix),
        .INSTR_DONE_I(instr_done), .T_STATE_O(t_state), .CYCLE_START_O(cyc_start), .BUS_HELD_O(bus_held),
        .HELD_LINE_O(held_line));
    rqgt_master rqgt_master_i (.REF_CLK_I(clk), .RST_I(rst), .PINS(pins_if.mst), .LINE_SEL_I(line_sel),
        .BUS_WANT_I(bus_want), .BUS_OWNED_O(bus_owned), .BUSY_O(busy));
    rqgt_props rqgt_props_i (.REF_CLK_I(clk), .RST_I(rst), .dev_rg_oe_i(pins_if.dev_rg_oe),
        .mst_rg_oe_i(pins_if.mst_rg_oe), .rg_n_i(pins_if.rg_n),
        .bus_exclusive_n_oe_i(pins_if.bus_exclusive_n_oe), .status_oe_i(pins_if.status_oe));
    ////////////////////////////////////////
    // compare, wait and closing tasks; samples taken at the edge see settled values
    task automatic chk1(input logic got, input logic exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask
    task automatic chk3(input logic [2:0] got, input logic [2:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wait_held(input logic v);
        for (int i = 0; i < 80 && bus_held !== v; i++) @(posedge clk);
        chk1(bus_held, v, "hold wait");
    endtask
    task automatic wait_ts(input logic [2:0] ts);
        for (int i = 0; i < 40 && t_state !== ts; i++) @(posedge clk);
        chk3(t_state, ts, "t-state wait");
    endtask
    task automatic end_of_test();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    // scenarios
    task automatic t_idle_grant(input logic line);
        line_sel <= line;
        bus_want <= 1'b1;
        wait_held(1'b1);
        chk1(held_line, line, "held line");
        chk3(t_state, rqgt_pkg::TS_TH, "detached");
        chk3(pins_if.status, rqgt_pkg::STATUS_PASSIVE, "status float");
        chk1(pins_if.bus_exclusive_n, 1'b1, "excl float");
        bus_want <= 1'b0;
        wait_held(1'b0);
        chk3(t_state, rqgt_pkg::TS_T1, "reclaim idle");
    endtask
    // request in T1; an odd low byte pushes the grant one bus cycle on
    task automatic t_mem(input logic odd);
        int starts;
        starts = 0;
        line_sel <= 1'b0;
        cyc_kind <= 3'h5;
        odd_word <= odd;
        cyc_req <= 1'b1;
        bus_want <= 1'b1;
        for (int i = 0; i < 80 && bus_held !== 1'b1; i++) begin
            @(posedge clk);
            if (cyc_start === 1'b1) begin
                starts++;
                odd_word <= 1'b0;
            end
        end
        chk1(bus_held, 1'b1, "mem grant");
        chk1(starts == (odd ? 2 : 1), 1'b1, "cycles before grant");
        bus_want <= 1'b0;
        wait_held(1'b0);
        chk3(t_state, rqgt_pkg::TS_T4, "reclaim pending");
        cyc_req <= 1'b0;
        wait_ts(rqgt_pkg::TS_TI);
    endtask
    // the grant would float the exclusive pin, so the driven value is looked at for the release
    task automatic t_lock();
        lock_prefix <= 1'b1;
        @(posedge clk);
        lock_prefix <= 1'b0;
        line_sel <= 1'b1;
        bus_want <= 1'b1;
        @(posedge clk);
        chk1(pins_if.bus_exclusive_n, 1'b0, "lock on");
        repeat (10) @(posedge clk);
        chk1(bus_held, 1'b0, "grant withheld");
        chk1(pins_if.bus_exclusive_n, 1'b0, "lock stays");
        instr_done <= 1'b1;
        @(posedge clk);
        instr_done <= 1'b0;
        chk1(pins_if.bus_exclusive_n, 1'b0, "lock until done");
        repeat (2) @(posedge clk);
        chk1(pins_if.bus_exclusive_n_o, 1'b1, "lock off");
        wait_held(1'b1);
        bus_want <= 1'b0;
        wait_held(1'b0);
    endtask
    // acknowledge pair with a request pending: the grant waits for the second acknowledge
    task automatic t_irq_ack();
        cyc_kind <= rqgt_pkg::STATUS_IRQ_ACK;
        cyc_req <= 1'b1;
        line_sel <= 1'b0;
        bus_want <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            wait_ts(rqgt_pkg::TS_T2);
            chk3(pins_if.status, rqgt_pkg::STATUS_IRQ_ACK, "ack status");
            if (k == 1) cyc_req <= 1'b0;
            @(posedge clk);
            chk1(pins_if.bus_exclusive_n, k[0], "ack exclusive");
            chk1(bus_held, 1'b0, "no grant in ack pair");
        end
        wait_held(1'b1);
        bus_want <= 1'b0;
        wait_held(1'b0);
        wait_ts(rqgt_pkg::TS_TI);
    endtask
    // strap high: request ignored and exclusive pin floated; a mid-run reset frees the waiting master
    task automatic t_min_mode();
        strap <= ~rqgt_pkg::STRAP_MAX;
        line_sel <= 1'b0;
        bus_want <= 1'b1;
        repeat (8) @(posedge clk);
        chk1(bus_held, 1'b0, "min mode no grant");
        chk1(pins_if.bus_exclusive_n_oe, 1'b0, "min mode excl float");
        bus_want <= 1'b0;
        strap <= rqgt_pkg::STRAP_MAX;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk3(t_state, rqgt_pkg::TS_TI, "mid-run reset state");
        chk1(busy, 1'b0, "master reset");
        t_idle_grant(1'b0);
    endtask
    ////////////////////////////////////////
    // clock, watchdog and main sequence
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #20000;
        error_cnt++;
        $display("[ERR] %0t watchdog expired", $time);
        end_of_test();
    end
    initial begin
        error_cnt = 0;
        cmp_count = 0;
        rst = 1'b1;
        strap = rqgt_pkg::STRAP_MAX;
        cyc_req = 1'b0;
        cyc_kind = 3'h0;
        odd_word = 1'b0;
        lock_prefix = 1'b0;
        instr_done = 1'b0;
        line_sel = 1'b0;
        bus_want = 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk3(t_state, rqgt_pkg::TS_TI, "reset state");
        chk1(&pins_if.rg_n, 1'b1, "lines idle high");
        t_idle_grant(1'b0);
        t_idle_grant(1'b1);
        t_mem(1'b0);
        t_mem(1'b1);
        t_lock();
        t_irq_ack();
        t_min_mode();
        end_of_test();
    end
endmodule // local_bus_request_grant_tb
`default_nettype wire
